/* File: design/psb_pkg.sv */
// psb_pkg: constants and types shared by the bridge port, its segment agent and the fifo.
// assumes both ends run on a 100 MHz mclk and meet through psb_seg_if.
package psb_pkg;
  // ****************************************
  // segment pins, one bundle per party
  // ****************************************
  typedef struct packed {
    logic [31:0] ad;
    logic [3:0] cbe_n;
    logic frame_n;
    logic irdy_n;
    logic trdy_n;
    logic devsel_n;
    logic par;
  } psb_bus_s;
  localparam int BUS_W = $bits(psb_bus_s);
  typedef enum logic [1:0] {SPD_PCI, SPD_X100, SPD_X133} psb_speed_e;
  // ****************************************
  // commands, decode windows, lanes
  // ****************************************
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] BE_ALL_N = 4'h0;
  localparam logic [7:0] UP_TAG = 8'h80;
  localparam logic [19:0] INT_PAGE = 20'hfeb00;
  localparam logic [7:0] AGT_TAG = 8'h40;
  localparam logic [7:0] LANES_X4 = 8'h0f;
  localparam logic [7:0] LANES_X8 = 8'hff;
  localparam logic [5:0] GNT_NONE_N = 6'h3f;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_NS = 10;
  localparam int SEG_CLK_NS = 160;
  localparam int SEG_DIV = SEG_CLK_NS / CLK_NS;
  localparam logic [3:0] DIV_LAST = 4'(SEG_DIV - 1);
  localparam logic [3:0] HALF_LAST = 4'(SEG_DIV / 2 - 1);
  localparam logic [2:0] ABORT_LAST = 3'h4; // five segment clocks without devsel
  localparam logic [3:0] ACT_AT = 4'h2; // divider count once the rise has crossed the sync chain
  localparam int FIFO_W = 32;
  localparam int FIFO_D = 16;
  // even parity: ones over ad, cbe and par come out even
  function automatic logic even_par(input logic [31:0] ad, input logic [3:0] cbe_n);
    return ^{ad, cbe_n};
  endfunction : even_par
endpackage : psb_pkg

/* File: design/psb_seg_if.sv */
// psb_seg_if: the shared segment wires between bridge port and agent.
// assumes each party drives output and enable per pin; undriven pins pull high.
`timescale 1ns/1ps
`default_nettype none
interface psb_seg_if;
  psb_pkg::psb_bus_s dev_o;
  psb_pkg::psb_bus_s dev_oe;
  psb_pkg::psb_bus_s agt_o;
  psb_pkg::psb_bus_s agt_oe;
  psb_pkg::psb_bus_s segment_bus;
  logic segment_clk;
  logic segment_reset_out_n;
  logic [5:0] segment_grant_n;
  logic [5:0] segment_request_n;
  // wire level per pin; pull-up keeps active-low lines deasserted
  always_comb begin
    for (int i = 0; i < psb_pkg::BUS_W; i++) begin
      segment_bus[i] = dev_oe[i] ? dev_o[i] : (agt_oe[i] ? agt_o[i] : 1'b1);
    end
  end
  modport dev (output dev_o, dev_oe, segment_clk, segment_reset_out_n, segment_grant_n,
               input segment_bus, segment_request_n);
  modport agt (output agt_o, agt_oe, segment_request_n,
               input segment_bus, segment_clk, segment_reset_out_n, segment_grant_n);
endinterface : psb_seg_if
`default_nettype wire

/* File: design/psb_fifo.sv */
// psb_fifo: valid/ready fifo, depth a power of two.
// assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module psb_fifo #(
  parameter int W = 32,
  parameter int D = 16
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } psb_fifo_s;
  psb_fifo_s st_ff, nxt_st;
  logic [W-1:0] mem [D];
  // pointers carry a wrap bit so full and empty differ
  assign in_ready = (st_ff.wp - st_ff.rp) != (AW + 1)'(D);
  assign out_valid = st_ff.wp != st_ff.rp;
  assign out_data = mem[st_ff.rp[AW-1:0]];
  // pointer advance
  always_comb begin
    nxt_st = st_ff;
    if (in_valid & in_ready) begin
      nxt_st.wp = st_ff.wp + (AW + 1)'(1);
    end
    if (out_valid & out_ready) begin
      nxt_st.rp = st_ff.rp + (AW + 1)'(1);
    end
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  // storage has no reset; only written words are ever read
  always_ff @(posedge mclk) begin
    if (in_valid & in_ready) begin
      mem[st_ff.wp[AW-1:0]] <= in_data;
    end
  end
endmodule : psb_fifo
`default_nettype wire

/* File: design/psb_bridge_port.sv */
// psb_bridge_port: segment side of the serial-to-parallel bridge: target, initiator,
// six-way arbiter, segment clock and reset, lane enables and speed straps.
// assumes mclk 100 MHz; the agent end joins through psb_seg_if.dev.
//
// What this block does
// - names ending _n are active low
// - x4 uses lanes 3:0, x8 all eight
// - fast enable picks 133 MHz, else 100
// - fast enable counts only when pci-x capable
// - initiator drives address, data by direction
// - command in address, byte enables in data
// - claim upstream and internal addresses as target
// - devsel from target answers own transactions
// - devsel floats from segment reset onward
// - frame marks start and last data phase
// - six low-active grants paired with requests
// - pci-x mode only if all capable
// - data phase ends on irdy and trdy
// - even parity over ad, cbe, one clock later
// - segment reset from bridge reset or bit
`timescale 1ns/1ps
`default_nettype none
module psb_bridge_port (
  input wire logic mclk,
  input wire logic reset,
  psb_seg_if.dev seg,
  input wire logic bridge_reset_in_n,
  input wire logic sec_reset_bit,
  input wire logic lane_x8,
  input wire logic [7:0] serial_rx_pos,
  input wire logic [7:0] serial_rx_neg,
  input wire logic [7:0] tx_lane_bits,
  output logic [7:0] serial_tx_pos,
  output logic [7:0] serial_tx_neg,
  output logic [7:0] rx_lane_bits,
  input wire logic segment_pcix_capable,
  input wire logic pcix_fast_enable,
  output logic pcix_mode,
  output psb_pkg::psb_speed_e speed_cap,
  input wire logic ini_valid,
  output logic ini_ready,
  input wire logic ini_write,
  input wire logic [31:0] ini_addr,
  input wire logic [31:0] ini_wdata,
  output logic ini_done,
  output logic ini_abort,
  output logic [31:0] ini_rdata,
  input wire logic [31:0] tgt_rdata,
  output logic up_valid,
  input wire logic up_ready,
  output logic [31:0] up_data
);
  // ****************************************
  // state
  // ****************************************
  localparam int SYN_W = psb_pkg::BUS_W + 6 + 3 + 16;
  typedef enum logic [2:0] {
    ST_IDLE, ST_T_DATA, ST_T_TURN, ST_I_ADDR, ST_I_DATA, ST_I_TURN
  } psb_dev_st_e;
  typedef struct packed {
    logic [SYN_W-1:0] s1;
    logic [SYN_W-1:0] s2;
    logic [3:0] div;
    logic sclk;
    logic rst_out_n;
    logic pcix;
    logic fast;
    psb_dev_st_e st;
    psb_pkg::psb_bus_s o;
    psb_pkg::psb_bus_s oe;
    logic [5:0] gnt_n;
    logic [2:0] last;
    logic [2:0] wait_c;
    logic wr;
    logic [31:0] data;
    logic done;
    logic abort;
    logic [7:0] txp;
    logic [7:0] txn;
    logic [7:0] rxb;
  } psb_dev_s;
  psb_dev_s st_ff, nxt_st;
  psb_pkg::psb_bus_s b;
  logic [5:0] req_n;
  logic brst_n, cap, fast, edge_t, seg_rst, bus_idle, claim, done_ph, fifo_in_rdy, push;
  logic [7:0] rxp, rxn, lanes;
  // ****************************************
  // decode of the sampled segment
  // ****************************************
  assign {b, req_n, brst_n, cap, fast, rxp, rxn} = st_ff.s2;
  // act when the sync chain shows the pins as they stood at the bus clock rise;
  // acting later would see the agent's next-cycle values and miss completions
  assign edge_t = st_ff.div == psb_pkg::ACT_AT;
  assign seg_rst = reset | ~brst_n | sec_reset_bit;
  assign bus_idle = b.frame_n & b.irdy_n;
  assign done_ph = ~b.irdy_n & ~b.trdy_n;
  assign claim = ~b.frame_n & b.irdy_n
                 & ((b.ad[31:24] == psb_pkg::UP_TAG) | (b.ad[31:12] == psb_pkg::INT_PAGE))
                 & ((b.cbe_n == psb_pkg::CMD_MEM_RD) | (b.cbe_n == psb_pkg::CMD_MEM_WR));
  assign lanes = lane_x8 ? psb_pkg::LANES_X8 : psb_pkg::LANES_X4;
  assign push = edge_t & (st_ff.st == ST_T_DATA) & st_ff.wr & done_ph;
  // own transactions start only with no grant out and a quiet bus
  assign ini_ready = edge_t & (st_ff.st == ST_IDLE) & (&st_ff.gnt_n) & bus_idle & ~seg_rst & ~claim;
  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [2:0] idx;
    logic rdy;
    idx = '0;
    rdy = 1'b0;
    nxt_st = st_ff;
    nxt_st.s1 = {seg.segment_bus, seg.segment_request_n, bridge_reset_in_n,
                 segment_pcix_capable, pcix_fast_enable, serial_rx_pos, serial_rx_neg};
    nxt_st.s2 = st_ff.s1;
    nxt_st.div = (st_ff.div == psb_pkg::DIV_LAST) ? 4'h0 : st_ff.div + 4'h1;
    nxt_st.sclk = nxt_st.div <= psb_pkg::HALF_LAST;
    nxt_st.done = 1'b0;
    nxt_st.abort = 1'b0;
    nxt_st.rst_out_n = ~seg_rst;
    nxt_st.txp = tx_lane_bits & lanes;
    nxt_st.txn = ~tx_lane_bits & lanes;
    nxt_st.rxb = rxp & ~rxn & lanes;
    // straps follow the pins while the segment is in reset, frozen after
    if (!st_ff.rst_out_n) begin
      nxt_st.pcix = cap;
      nxt_st.fast = cap & fast;
    end
    if (seg_rst) begin
      nxt_st.st = ST_IDLE;
      nxt_st.oe = '0;
      nxt_st.gnt_n = psb_pkg::GNT_NONE_N;
    end else if (edge_t) begin
      case (st_ff.st)
        ST_IDLE: begin
          if (claim) begin
            nxt_st.st = ST_T_DATA;
            nxt_st.wr = b.cbe_n == psb_pkg::CMD_MEM_WR;
            nxt_st.o.devsel_n = 1'b0;
            nxt_st.o.trdy_n = 1'b1;
            nxt_st.oe.devsel_n = 1'b1;
            nxt_st.oe.trdy_n = 1'b1;
          end else if (ini_valid & ini_ready) begin
            nxt_st.st = ST_I_ADDR;
            nxt_st.wr = ini_write;
            nxt_st.data = ini_wdata;
            nxt_st.wait_c = '0;
            nxt_st.o.frame_n = 1'b0;
            nxt_st.o.irdy_n = 1'b1;
            nxt_st.o.ad = ini_addr;
            nxt_st.o.cbe_n = ini_write ? psb_pkg::CMD_MEM_WR : psb_pkg::CMD_MEM_RD;
            nxt_st.oe.frame_n = 1'b1;
            nxt_st.oe.irdy_n = 1'b1;
            nxt_st.oe.ad = '1;
            nxt_st.oe.cbe_n = '1;
          end
        end
        ST_T_DATA: begin
          // one wait state after each push: the fifo level is only known a cycle later
          rdy = ~st_ff.wr | (fifo_in_rdy & ~push);
          nxt_st.o.trdy_n = ~rdy;
          nxt_st.o.ad = tgt_rdata;
          nxt_st.oe.ad = {32{~st_ff.wr}};
          if (done_ph & b.frame_n) begin
            nxt_st.st = ST_T_TURN;
            nxt_st.o.devsel_n = 1'b1;
            nxt_st.o.trdy_n = 1'b1;
            nxt_st.oe.ad = '0;
          end
        end
        ST_I_ADDR: begin
          // single data phase, so frame rises as irdy drops
          nxt_st.st = ST_I_DATA;
          nxt_st.o.frame_n = 1'b1;
          nxt_st.o.irdy_n = 1'b0;
          nxt_st.o.ad = st_ff.data;
          nxt_st.oe.ad = {32{st_ff.wr}};
          nxt_st.o.cbe_n = psb_pkg::BE_ALL_N;
        end
        ST_I_DATA: begin
          nxt_st.wait_c = st_ff.wait_c + 3'h1;
          if (~b.devsel_n & done_ph) begin
            nxt_st.data = st_ff.wr ? st_ff.data : b.ad;
            nxt_st.done = 1'b1;
            nxt_st.st = ST_I_TURN;
            nxt_st.o.irdy_n = 1'b1;
            nxt_st.oe.ad = '0;
          end else if (b.devsel_n & (st_ff.wait_c == psb_pkg::ABORT_LAST)) begin
            nxt_st.abort = 1'b1;
            nxt_st.st = ST_I_TURN;
            nxt_st.o.irdy_n = 1'b1;
            nxt_st.oe.ad = '0;
          end
        end
        ST_T_TURN, ST_I_TURN: begin
          nxt_st.st = ST_IDLE;
          nxt_st.oe = '0;
        end
        default: begin
          nxt_st.st = ST_IDLE;
        end
      endcase
      // parity trails the lines it covers by one segment clock
      nxt_st.o.par = psb_pkg::even_par(st_ff.o.ad, st_ff.o.cbe_n);
      nxt_st.oe.par = st_ff.oe.ad[0];
      // arbiter: hold the grant while its owner requests, else round robin
      if (!(&st_ff.gnt_n)) begin
        if (!(|(~st_ff.gnt_n & ~req_n))) begin
          nxt_st.gnt_n = psb_pkg::GNT_NONE_N;
        end
      end else if ((st_ff.st == ST_IDLE) & bus_idle & ~claim & ~(ini_valid & ini_ready)) begin
        for (int i = 1; i <= 6; i++) begin
          idx = 3'((int'(st_ff.last) + i) % 6);
          if ((&nxt_st.gnt_n) & ~req_n[idx]) begin
            nxt_st.gnt_n[idx] = 1'b0;
            nxt_st.last = idx;
          end
        end
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      st_ff <= '0;
      st_ff.gnt_n <= psb_pkg::GNT_NONE_N;
    end else begin
      st_ff <= nxt_st;
    end
  end
  // ****************************************
  // inbound write buffer toward the upstream link
  // ****************************************
  psb_fifo #(.W(psb_pkg::FIFO_W), .D(psb_pkg::FIFO_D)) u_fifo (
    .mclk(mclk),
    .reset(reset),
    .in_valid(push),
    .in_ready(fifo_in_rdy),
    .in_data(b.ad),
    .out_valid(up_valid),
    .out_ready(up_ready),
    .out_data(up_data)
  );
  // ****************************************
  // outputs
  // ****************************************
  assign seg.dev_o = st_ff.o;
  assign seg.dev_oe = st_ff.oe;
  assign seg.segment_clk = st_ff.sclk;
  assign seg.segment_reset_out_n = st_ff.rst_out_n;
  assign seg.segment_grant_n = st_ff.gnt_n;
  assign serial_tx_pos = st_ff.txp;
  assign serial_tx_neg = st_ff.txn;
  assign rx_lane_bits = st_ff.rxb;
  assign pcix_mode = st_ff.pcix;
  assign speed_cap = !st_ff.pcix ? psb_pkg::SPD_PCI
                   : (st_ff.fast ? psb_pkg::SPD_X133 : psb_pkg::SPD_X100);
  assign ini_done = st_ff.done;
  assign ini_abort = st_ff.abort;
  assign ini_rdata = st_ff.data;
endmodule : psb_bridge_port
`default_nettype wire

/* File: design/psb_segment_agent.sv */
// psb_segment_agent: one segment device: initiator on request slot 0 and a one-word target.
// assumes the bridge port drives segment clock, reset and grants through psb_seg_if.agt.
`timescale 1ns/1ps
`default_nettype none
module psb_segment_agent (
  input wire logic mclk,
  input wire logic reset,
  psb_seg_if.agt seg,
  input wire logic a_valid,
  output logic a_ready,
  input wire logic a_write,
  input wire logic [31:0] a_addr,
  input wire logic [31:0] a_wdata,
  output logic a_done,
  output logic a_abort,
  output logic [31:0] a_rdata,
  output logic [31:0] agt_word
);
  // ****************************************
  // state
  // ****************************************
  localparam int SYN_W = psb_pkg::BUS_W + 6 + 2;
  typedef enum logic [2:0] {
    AS_IDLE, AS_REQ, AS_ADDR, AS_DATA, AS_TURN, AS_T_DATA, AS_T_TURN
  } psb_agt_st_e;
  typedef struct packed {
    logic [SYN_W-1:0] s1;
    logic [SYN_W-1:0] s2;
    logic sclk_d;
    psb_agt_st_e st;
    psb_pkg::psb_bus_s o;
    psb_pkg::psb_bus_s oe;
    logic req_n;
    logic [2:0] wait_c;
    logic wr;
    logic [31:0] addr;
    logic [31:0] data;
    logic [31:0] word;
    logic done;
    logic abort;
  } psb_agt_s;
  psb_agt_s st_ff, nxt_st;
  psb_pkg::psb_bus_s b;
  logic [5:0] gnt_n;
  logic sclk, rst_n, edge_t, bus_idle, claim, done_ph;
  assign {b, gnt_n, sclk, rst_n} = st_ff.s2;
  // the segment clock is a sampled pin: its rising edge marks each bus clock
  assign edge_t = sclk & ~st_ff.sclk_d;
  assign bus_idle = b.frame_n & b.irdy_n;
  assign done_ph = ~b.irdy_n & ~b.trdy_n;
  assign claim = ~b.frame_n & b.irdy_n & (b.ad[31:24] == psb_pkg::AGT_TAG)
                 & ((b.cbe_n == psb_pkg::CMD_MEM_RD) | (b.cbe_n == psb_pkg::CMD_MEM_WR));
  assign a_ready = (st_ff.st == AS_IDLE) & rst_n & ~(edge_t & claim);
  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = {seg.segment_bus, seg.segment_grant_n, seg.segment_clk, seg.segment_reset_out_n};
    nxt_st.s2 = st_ff.s1;
    nxt_st.sclk_d = sclk;
    nxt_st.done = 1'b0;
    nxt_st.abort = 1'b0;
    if (!rst_n) begin
      // a pending request is dropped by a segment reset
      nxt_st.st = AS_IDLE;
      nxt_st.oe = '0;
      nxt_st.req_n = 1'b1;
    end else begin
      if (a_valid & a_ready) begin
        nxt_st.st = AS_REQ;
        nxt_st.wr = a_write;
        nxt_st.addr = a_addr;
        nxt_st.data = a_wdata;
        nxt_st.req_n = 1'b0;
      end
      if (edge_t) begin
        case (st_ff.st)
          AS_IDLE: begin
            if (claim) begin
              nxt_st.st = AS_T_DATA;
              nxt_st.wr = b.cbe_n == psb_pkg::CMD_MEM_WR;
              nxt_st.o.devsel_n = 1'b0;
              nxt_st.o.trdy_n = 1'b0;
              nxt_st.oe.devsel_n = 1'b1;
              nxt_st.oe.trdy_n = 1'b1;
              // trdy goes low at once, so read data must be on the lines with it
              nxt_st.o.ad = st_ff.word;
              nxt_st.oe.ad = {32{b.cbe_n == psb_pkg::CMD_MEM_RD}};
            end
          end
          AS_REQ: begin
            if (~gnt_n[0] & bus_idle) begin
              nxt_st.st = AS_ADDR;
              nxt_st.wait_c = '0;
              nxt_st.o.frame_n = 1'b0;
              nxt_st.o.irdy_n = 1'b1;
              nxt_st.o.ad = st_ff.addr;
              nxt_st.o.cbe_n = st_ff.wr ? psb_pkg::CMD_MEM_WR : psb_pkg::CMD_MEM_RD;
              nxt_st.oe.frame_n = 1'b1;
              nxt_st.oe.irdy_n = 1'b1;
              nxt_st.oe.ad = '1;
              nxt_st.oe.cbe_n = '1;
            end
          end
          AS_ADDR: begin
            nxt_st.st = AS_DATA;
            nxt_st.o.frame_n = 1'b1;
            nxt_st.o.irdy_n = 1'b0;
            nxt_st.o.ad = st_ff.data;
            nxt_st.oe.ad = {32{st_ff.wr}};
            nxt_st.o.cbe_n = psb_pkg::BE_ALL_N;
          end
          AS_DATA: begin
            nxt_st.wait_c = st_ff.wait_c + 3'h1;
            if ((~b.devsel_n & done_ph) | (b.devsel_n & (st_ff.wait_c == psb_pkg::ABORT_LAST))) begin
              nxt_st.done = ~b.devsel_n;
              nxt_st.abort = b.devsel_n;
              nxt_st.data = (st_ff.wr | b.devsel_n) ? st_ff.data : b.ad;
              nxt_st.st = AS_TURN;
              nxt_st.o.irdy_n = 1'b1;
              nxt_st.oe.ad = '0;
              nxt_st.req_n = 1'b1;
            end
          end
          AS_T_DATA: begin
            nxt_st.o.ad = st_ff.word;
            nxt_st.oe.ad = {32{~st_ff.wr}};
            if (done_ph) begin
              if (st_ff.wr) begin
                nxt_st.word = b.ad;
              end
              if (b.frame_n) begin
                nxt_st.st = AS_T_TURN;
                nxt_st.o.devsel_n = 1'b1;
                nxt_st.o.trdy_n = 1'b1;
                nxt_st.oe.ad = '0;
              end
            end
          end
          AS_TURN, AS_T_TURN: begin
            nxt_st.st = AS_IDLE;
            nxt_st.oe = '0;
          end
          default: begin
            nxt_st.st = AS_IDLE;
          end
        endcase
        nxt_st.o.par = psb_pkg::even_par(st_ff.o.ad, st_ff.o.cbe_n);
        nxt_st.oe.par = st_ff.oe.ad[0];
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      st_ff <= '0;
      st_ff.req_n <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end
  // ****************************************
  // outputs
  // ****************************************
  assign seg.agt_o = st_ff.o;
  assign seg.agt_oe = st_ff.oe;
  assign seg.segment_request_n = {5'h1f, st_ff.req_n};
  assign a_done = st_ff.done;
  assign a_abort = st_ff.abort;
  assign a_rdata = st_ff.data;
  assign agt_word = st_ff.word;
endmodule : psb_segment_agent
`default_nettype wire

/* File: verif/psb_properties.sv */
// psb_properties: wire checks on the segment between bridge port and agent.
// assumes it sits beside psb_seg_if, mclk clocked, reset synchronous high.
`timescale 1ns/1ps
`default_nettype none
module psb_properties (
  input wire logic mclk,
  input wire logic reset,
  input wire psb_pkg::psb_bus_s segment_bus,
  input wire psb_pkg::psb_bus_s dev_oe,
  input wire psb_pkg::psb_bus_s agt_oe,
  input wire logic segment_clk,
  input wire logic segment_reset_out_n,
  input wire logic [5:0] segment_grant_n,
  input wire logic [5:0] segment_request_n
);
  // ****************
  // bus clock samples
  // ****************
  logic clk_ff, drv_ff, fr_ff;
  logic [35:0] adc_ff;
  wire logic rise = segment_clk && !clk_ff;
  wire logic aph = rise && fr_ff && !segment_bus.frame_n;
  // sample at the bus clock rise, where neither party is switching
  always_ff @(posedge mclk) begin
    clk_ff <= segment_clk;
    if (reset || !segment_reset_out_n) begin
      drv_ff <= 1'b0;
      fr_ff <= 1'b1;
    end else if (rise) begin
      drv_ff <= dev_oe.ad[0] | agt_oe.ad[0];
      fr_ff <= segment_bus.frame_n;
    end
    if (rise) adc_ff <= {segment_bus.ad, segment_bus.cbe_n};
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // ****************
  // properties
  // ****************
  property p_one_grant; $onehot0(~segment_grant_n); endproperty
  a_one_grant: assert property (p_one_grant) else $error("two grants");
  property p_grant_pair; $fell(segment_grant_n[0]) |-> !segment_request_n[0]
    && (&segment_grant_n[5:1]); endproperty
  a_grant_pair: assert property (p_grant_pair) else $error("grant unpaired");
  // agent sees the segment reset through a sync chain, hence six cycles
  property p_reset_idle; !segment_reset_out_n [*6] |-> dev_oe == '0 && agt_oe == '0
    && segment_grant_n == 6'h3f; endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("driven in reset");
  property p_devsel_float; $fell(segment_reset_out_n) |=> !dev_oe.devsel_n [*4]; endproperty
  a_devsel_float: assert property (p_devsel_float) else $error("devsel driven");
  property p_parity; rise && drv_ff |-> segment_bus.par == ^adc_ff; endproperty
  a_parity: assert property (p_parity) else $error("bad parity");
  property p_addr_phase; aph |-> segment_bus.irdy_n && segment_bus.trdy_n; endproperty
  a_addr_phase: assert property (p_addr_phase) else $error("ready in address");
  property p_claim; aph && segment_bus.cbe_n[3:1] == 3'h3
    && segment_bus.ad[31:24] == psb_pkg::UP_TAG |-> ##[1:40] !segment_bus.devsel_n; endproperty
  a_claim: assert property (p_claim) else $error("upstream not claimed");
  property p_last_phase; rise && !segment_bus.irdy_n && !segment_bus.trdy_n
    && segment_bus.frame_n |-> ##[1:20] segment_bus.irdy_n && segment_bus.trdy_n; endproperty
  a_last_phase: assert property (p_last_phase) else $error("ready held");
  c_data: cover property (rise && !segment_bus.irdy_n && !segment_bus.trdy_n);
  c_grant: cover property ($fell(segment_grant_n[0]));
  c_seg_reset: cover property ($fell(segment_reset_out_n));
endmodule : psb_properties
`default_nettype wire

/* File: verif/psb_bridge_port_tb_top.sv */
// psb_bridge_port_tb_top: bridge port and segment agent joined over psb_seg_if.
// assumes 100 MHz mclk; the bridge makes the segment clock itself.
`timescale 1ns/1ps
`default_nettype none
module psb_bridge_port_tb_top;
  logic mclk, reset, brst_n, sec_rst, x8, cap, fast, pmode, last;
  logic iv, ir, iw, idone, iab, av, ar, aw, adone, aab, upv, upr;
  logic [7:0] rxp, rxn, txb, txp, txn, rxb, msk;
  logic [31:0] iadr, iwd, ird, trd, upd, aadr, awd, ard, aword;
  psb_pkg::psb_speed_e spd, spd_x;
  int error_cnt, checks;
  psb_seg_if seg();
  psb_bridge_port u_psb_bridge_port (.mclk(mclk), .reset(reset), .seg(seg.dev),
    .bridge_reset_in_n(brst_n), .sec_reset_bit(sec_rst), .lane_x8(x8),
    .serial_rx_pos(rxp), .serial_rx_neg(rxn), .tx_lane_bits(txb), .serial_tx_pos(txp),
    .serial_tx_neg(txn), .rx_lane_bits(rxb), .segment_pcix_capable(cap),
    .pcix_fast_enable(fast), .pcix_mode(pmode), .speed_cap(spd), .ini_valid(iv),
    .ini_ready(ir), .ini_write(iw), .ini_addr(iadr), .ini_wdata(iwd), .ini_done(idone),
    .ini_abort(iab), .ini_rdata(ird), .tgt_rdata(trd), .up_valid(upv), .up_ready(upr),
    .up_data(upd));
  psb_segment_agent u_psb_segment_agent (.mclk(mclk), .reset(reset), .seg(seg.agt),
    .a_valid(av), .a_ready(ar), .a_write(aw), .a_addr(aadr), .a_wdata(awd),
    .a_done(adone), .a_abort(aab), .a_rdata(ard), .agt_word(aword));
  psb_properties u_psb_properties (.mclk(mclk), .reset(reset),
    .segment_bus(seg.segment_bus), .dev_oe(seg.dev_oe), .agt_oe(seg.agt_oe),
    .segment_clk(seg.segment_clk), .segment_reset_out_n(seg.segment_reset_out_n),
    .segment_grant_n(seg.segment_grant_n), .segment_request_n(seg.segment_request_n));
  // ****************
  // clock and tasks
  // ****************
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report;
    $display("checks=%0d errors=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  // a spent wait bound counts as a mismatch and ends the run
  task automatic hang;
    chk(32'h0, 32'h1);
    final_report();
  endtask : hang
  // one transfer: side 1 is the bridge initiator, 0 the agent; held until taken
  task automatic op(input logic side, input logic w, input logic [31:0] a,
                    input logic [31:0] d);
    int n;
    {iw, iadr, iwd, aw, aadr, awd} = {w, a, d, w, a, d};
    {iv, av} = {side, !side};
    for (n = 0; (side ? ir : ar) !== 1'b1; n++) begin
      if (n > 4000) hang();
      @(negedge mclk);
    end
    @(negedge mclk);
    {iv, av} = 2'b00;
    for (n = 0; (side ? (idone | iab) : (adone | aab)) !== 1'b1; n++) begin
      if (n > 4000) hang();
      @(negedge mclk);
    end
  endtask : op
  task automatic pop(input logic [31:0] e);
    for (int n = 0; upv !== 1'b1; n++) begin
      if (n > 200) hang();
      @(negedge mclk);
    end
    chk(upd, e);
    upr = 1'b1;
    @(negedge mclk);
    upr = 1'b0;
    @(negedge mclk); // a back-to-back pop raises ready in a later step
  endtask : pop
  // ****************
  // tests
  // ****************
  initial begin
    {reset, brst_n, sec_rst, x8, cap, fast, iv, av, upr, iw, aw, last} = 12'hc00;
    {rxp, rxn, txb, iadr, iwd, aadr, awd, trd} = '0;
    {error_cnt, checks} = '0;
    repeat (10) @(negedge mclk);
    chk(32'(seg.segment_reset_out_n), 32'h0);
    chk(32'(seg.segment_grant_n), 32'h3f);
    reset = 1'b0;
    repeat (8) @(negedge mclk);
    chk(32'(seg.segment_reset_out_n), 32'h1);
    // unused lanes stay quiet in the narrow width
    for (int m = 0; m < 2; m++) begin
      {x8, txb, rxp, rxn} = {m[0], 8'ha5, 8'h5a, 8'ha5};
      msk = m ? psb_pkg::LANES_X8 : psb_pkg::LANES_X4;
      repeat (4) @(negedge mclk);
      chk(32'(txp), 32'(txb & msk));
      chk(32'(rxb & ~msk), 32'h0);
      chk(32'(txn), 32'(~txb & msk));
      chk(32'(rxb), 32'(8'h5a & msk));
    end
    $display("test lanes done");
    // straps are taken while the segment sits in reset, both reset causes
    for (int k = 0; k < 4; k++) begin
      {cap, fast} = k[1:0];
      if (k[0]) brst_n = 1'b0;
      else sec_rst = 1'b1;
      repeat (8) @(negedge mclk);
      chk(32'(seg.segment_reset_out_n), 32'h0);
      {brst_n, sec_rst} = 2'b10;
      repeat (12) @(negedge mclk);
      spd_x = !cap ? psb_pkg::SPD_PCI : (fast ? psb_pkg::SPD_X133 : psb_pkg::SPD_X100);
      chk(32'(pmode), 32'(cap));
      chk(32'(spd), 32'(spd_x));
    end
    $display("test speed done");
    trd = 32'hc0ffee01;
    op(1'b0, 1'b1, 32'h80000010, 32'h1234abcd);
    chk(32'(aab), 32'h0);
    pop(32'h1234abcd);
    op(1'b0, 1'b0, 32'hfeb00004, 32'h0);
    chk(ard, trd);
    op(1'b1, 1'b1, 32'h40000020, 32'h5a5a0f0f);
    chk(aword, 32'h5a5a0f0f);
    op(1'b1, 1'b0, 32'h40000020, 32'h0);
    chk(ird, 32'h5a5a0f0f);
    for (int s = 0; s < 2; s++) begin
      op(s[0], 1'b1, 32'h10000000, 32'h0);
      chk(32'(s ? iab : aab), 32'h1);
    end
    $display("test transfers done");
    // fill the fifo, stall the 17th write in wait states, then drain in order
    for (int i = 0; i < 16; i++) op(1'b0, 1'b1, 32'h80000100, 32'(i));
    fork
      begin
        op(1'b0, 1'b1, 32'h80000100, 32'h10);
        last = 1'b1;
      end
      begin
        repeat (800) @(negedge mclk);
        chk(32'(last), 32'h0);
        for (int i = 0; i < 17; i++) pop(32'(i));
      end
    join
    $display("test fifo done");
    final_report();
  end
endmodule : psb_bridge_port_tb_top
`default_nettype wire
